// >>> hw/rtas_pkg.sv
package rtas_pkg;
	// ****************************************
	// timing base
	// ****************************************
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned LOS_PERIOD_MS = 2000;
	localparam int unsigned RATE_PERIOD_MS = 500;
	localparam int unsigned DESIG_TIMEOUT_MS = 30000;
	localparam int unsigned SETTLE_MS = 2500;
	localparam int unsigned LOS_CYC = LOS_PERIOD_MS * (CLK_HZ / 1000);
	localparam int unsigned RATE_CYC = RATE_PERIOD_MS * (CLK_HZ / 1000);
	localparam int unsigned DESIG_CYC = DESIG_TIMEOUT_MS * (CLK_HZ / 1000);
	localparam int unsigned SETTLE_CYC = SETTLE_MS * (CLK_HZ / 1000);

	// ****************************************
	// geometry limits
	// ****************************************
	localparam logic [15:0] RANGE_MAX_NM = 16'h0190;
	// angle units: centidegrees
	localparam logic [15:0] TRACK_ERR_CDEG = 16'h0032;
	localparam logic [15:0] OFF_Z_MAX_CDEG = 16'h0BB8;
	localparam logic [1:0] COVERAGE_ONE = 2'h1;
	localparam logic [15:0] RATE_GAIN_SHIFT = 16'h0002;

	typedef enum {
		ST_IDLE, ST_RANGE, ST_ATTITUDE, ST_AUTO, ST_ZERO, ST_FLAGS,
		ST_DESIG_INIT, ST_COVER, ST_DESIG, ST_ALARM, ST_SEARCH,
		ST_SETTLE, ST_DATA
	} rtas_state_e;
endpackage

// >>> hw/rtas_seq.sv
`timescale 1ns/1ps
`default_nettype none
module rtas_seq #(
	parameter int unsigned LOS_CYC = rtas_pkg::LOS_CYC,
	parameter int unsigned RATE_CYC = rtas_pkg::RATE_CYC,
	parameter int unsigned DESIG_CYC = rtas_pkg::DESIG_CYC,
	parameter int unsigned SETTLE_CYC = rtas_pkg::SETTLE_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic manual_select,
	input wire logic [15:0] range_nm,
	output logic los_compute,
	input wire logic attitude_done,
	output logic attitude_req,
	input wire logic auto_mode_pin,
	input wire logic zeroing_pin,
	input wire logic data_good_pin,
	output logic zero_req,
	input wire logic [1:0] coverage_region,
	output logic coverage_cmd,
	input wire logic signed [15:0] point_err_cdeg,
	input wire logic [15:0] off_z_cdeg,
	output logic signed [15:0] rate_cmd,
	output logic rate_strobe,
	output logic track_enable,
	input wire logic op_repeat,
	input wire logic op_search,
	output logic range_alarm,
	output logic desig_alarm,
	output logic manual_flag,
	output logic search_flag,
	output logic data_read_enable,
	output logic [3:0] state_code
);
	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [2:0] sync1, sync2;
	logic auto_mode, zeroing, data_good;
	// all three discretes come from the radar's own clock world
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1 <= 3'h0;
			sync2 <= 3'h0;
		end else begin
			sync1 <= {auto_mode_pin, zeroing_pin, data_good_pin};
			sync2 <= sync1;
		end
	end
	assign auto_mode = sync2[2];
	assign zeroing = sync2[1];
	assign data_good = sync2[0];

	// ****************************************
	// sequencer
	// ****************************************
	rtas_pkg::rtas_state_e state, next_state;
	logic [31:0] tmr, next_tmr, los_tmr, next_los_tmr, rate_tmr, next_rate_tmr;
	logic track_en, next_track_en, ralarm, next_ralarm, dalarm, next_dalarm;
	logic man, next_man, srch, next_srch, los_p, next_los_p, rate_p;
	logic next_rate_p, att_req, next_att_req, cov, next_cov;
	logic zreq, next_zreq, auto_d, next_auto_d, zpend, next_zpend;
	logic signed [15:0] rate, next_rate;
	logic [15:0] abs_err;

	assign abs_err = point_err_cdeg[15] ? 16'(-point_err_cdeg)
		: 16'(point_err_cdeg);

	// next-state logic; timers only run in the states that use them
	always_comb begin
		next_state = state;
		next_tmr = tmr;
		next_los_tmr = los_tmr;
		next_rate_tmr = rate_tmr;
		next_track_en = track_en;
		next_ralarm = ralarm;
		next_dalarm = dalarm;
		next_man = man;
		next_srch = srch;
		next_los_p = 1'b0;
		next_rate_p = 1'b0;
		next_rate = rate;
		next_att_req = 1'b0;
		next_cov = 1'b0;
		next_auto_d = auto_mode;
		next_zreq = auto_mode && !auto_d;
		// request stays pending until zeroing is seen; the synchroniser
		// delay would otherwise let the zero wait slip through early
		next_zpend = zreq || (zpend && !zeroing);
		case (state)
			rtas_pkg::ST_IDLE: begin
				next_srch = 1'b0;
				if (start) begin
					next_man = manual_select;
					next_los_p = 1'b1;
					next_state = rtas_pkg::ST_RANGE;
				end
			end
			rtas_pkg::ST_RANGE: begin
				if (range_nm > rtas_pkg::RANGE_MAX_NM) begin
					next_ralarm = 1'b1;
					next_state = rtas_pkg::ST_ALARM;
				end else begin
					next_att_req = 1'b1;
					next_state = rtas_pkg::ST_ATTITUDE;
				end
			end
			rtas_pkg::ST_ATTITUDE: begin
				if (attitude_done) begin
					next_state = rtas_pkg::ST_AUTO;
				end
			end
			rtas_pkg::ST_AUTO: begin
				if (auto_mode) begin
					next_state = rtas_pkg::ST_ZERO;
				end
			end
			rtas_pkg::ST_ZERO: begin
				if (!zeroing && !zreq && !zpend) begin
					next_state = rtas_pkg::ST_FLAGS;
				end
			end
			rtas_pkg::ST_FLAGS: begin
				// manual path leaves the designate loop to the operator
				if (!man && !srch) begin
					next_state = rtas_pkg::ST_DESIG_INIT;
				end else if (srch) begin
					next_state = rtas_pkg::ST_SEARCH;
				end else if (data_good) begin
					next_state = rtas_pkg::ST_SETTLE;
					next_tmr = 32'h0000_0000;
				end
			end
			rtas_pkg::ST_DESIG_INIT: begin
				next_track_en = 1'b0;
				next_state = rtas_pkg::ST_COVER;
			end
			rtas_pkg::ST_COVER: begin
				if (coverage_region != rtas_pkg::COVERAGE_ONE) begin
					next_cov = 1'b1;
				end else begin
					next_state = rtas_pkg::ST_DESIG;
					next_tmr = 32'h0000_0000;
					next_los_tmr = 32'h0000_0000;
					next_rate_tmr = 32'h0000_0000;
				end
			end
			rtas_pkg::ST_DESIG: begin
				next_tmr = tmr + 32'h0000_0001;
				next_los_tmr = los_tmr + 32'h0000_0001;
				next_rate_tmr = rate_tmr + 32'h0000_0001;
				if (los_tmr == LOS_CYC - 1) begin
					next_los_tmr = 32'h0000_0000;
					next_los_p = 1'b1;
				end
				if (rate_tmr == RATE_CYC - 1) begin
					next_rate_tmr = 32'h0000_0000;
					next_rate_p = 1'b1;
					next_rate = point_err_cdeg
						>>> rtas_pkg::RATE_GAIN_SHIFT;
				end
				if (abs_err <= rtas_pkg::TRACK_ERR_CDEG) begin
					next_track_en = 1'b1;
				end
				if (data_good) begin
					next_state = rtas_pkg::ST_SETTLE;
					next_tmr = 32'h0000_0000;
				end else if (tmr == DESIG_CYC - 1) begin
					next_dalarm = 1'b1;
					next_state = rtas_pkg::ST_ALARM;
				end
			end
			rtas_pkg::ST_ALARM: begin
				// range alarm only accepts a repeat; search needs designate alarm
				if (op_repeat) begin
					next_ralarm = 1'b0;
					next_dalarm = 1'b0;
					next_state = rtas_pkg::ST_IDLE;
				end else if (op_search && dalarm) begin
					next_dalarm = 1'b0;
					next_srch = 1'b1;
					next_track_en = 1'b1;
					next_state = rtas_pkg::ST_SEARCH;
				end
			end
			rtas_pkg::ST_SEARCH: begin
				// search pattern runs outside; lock ends it
				if (data_good) begin
					next_state = rtas_pkg::ST_SETTLE;
					next_tmr = 32'h0000_0000;
				end
			end
			rtas_pkg::ST_SETTLE: begin
				next_tmr = tmr + 32'h0000_0001;
				if (tmr == SETTLE_CYC - 1) begin
					next_state = rtas_pkg::ST_DATA;
				end
			end
			rtas_pkg::ST_DATA: begin
				if (off_z_cdeg > rtas_pkg::OFF_Z_MAX_CDEG) begin
					next_att_req = 1'b1;
					next_state = rtas_pkg::ST_ATTITUDE;
				end
			end
			default: next_state = rtas_pkg::ST_IDLE;
		endcase
	end

	// state registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= rtas_pkg::ST_IDLE;
			tmr <= 32'h0000_0000;
			los_tmr <= 32'h0000_0000;
			rate_tmr <= 32'h0000_0000;
			track_en <= 1'b0;
			ralarm <= 1'b0;
			dalarm <= 1'b0;
			man <= 1'b0;
			srch <= 1'b0;
			los_p <= 1'b0;
			rate_p <= 1'b0;
			rate <= 16'sh0000;
			att_req <= 1'b0;
			cov <= 1'b0;
			zreq <= 1'b0;
			auto_d <= 1'b0;
			zpend <= 1'b0;
		end else begin
			state <= next_state;
			tmr <= next_tmr;
			los_tmr <= next_los_tmr;
			rate_tmr <= next_rate_tmr;
			track_en <= next_track_en;
			ralarm <= next_ralarm;
			dalarm <= next_dalarm;
			man <= next_man;
			srch <= next_srch;
			los_p <= next_los_p;
			rate_p <= next_rate_p;
			rate <= next_rate;
			att_req <= next_att_req;
			cov <= next_cov;
			zreq <= next_zreq;
			auto_d <= next_auto_d;
			zpend <= next_zpend;
		end
	end

	assign los_compute = los_p;
	assign attitude_req = att_req;
	assign zero_req = zreq;
	assign coverage_cmd = cov;
	assign rate_cmd = rate;
	assign rate_strobe = rate_p;
	assign track_enable = track_en;
	assign range_alarm = ralarm;
	assign desig_alarm = dalarm;
	assign manual_flag = man;
	assign search_flag = srch;
	assign data_read_enable = (state == rtas_pkg::ST_DATA);
	assign state_code = 4'(state);

	// ****************************************
	// checks
	// ****************************************
	chk_range_alarm: assert property (@(posedge clk) disable iff (rst)
		state == rtas_pkg::ST_RANGE && range_nm > rtas_pkg::RANGE_MAX_NM
		|=> range_alarm && state == rtas_pkg::ST_ALARM)
		else $error("range over limit did not alarm");
	chk_auto_gate: assert property (@(posedge clk) disable iff (rst)
		state == rtas_pkg::ST_AUTO && !auto_mode |=> state == rtas_pkg::ST_AUTO)
		else $error("left auto check without auto mode");
	chk_zero_block: assert property (@(posedge clk) disable iff (rst)
		state == rtas_pkg::ST_ZERO && zeroing |=> state == rtas_pkg::ST_ZERO)
		else $error("advanced during zeroing");
	chk_track_drop: assert property (@(posedge clk) disable iff (rst)
		state == rtas_pkg::ST_DESIG_INIT |=> !track_enable)
		else $error("track enable kept at designate start");
	chk_rate_period: assert property (@(posedge clk) disable iff (rst)
		rate_strobe |-> ##1 !rate_strobe [*3])
		else $error("rate strobes too close");
	chk_lock_settle: assert property (@(posedge clk) disable iff (rst)
		state == rtas_pkg::ST_DESIG && data_good |=> state == rtas_pkg::ST_SETTLE)
		else $error("lock did not end designation");
	chk_timeout_alarm: assert property (@(posedge clk) disable iff (rst)
		state == rtas_pkg::ST_DESIG && !data_good && tmr == DESIG_CYC - 1
		|=> desig_alarm)
		else $error("designate timeout missed");
	chk_search_gate: assert property (@(posedge clk) disable iff (rst)
		$rose(search_flag) |-> $past(state) == rtas_pkg::ST_ALARM
		&& $past(dalarm))
		else $error("search entered without designate alarm");
	chk_alarm_sticky: assert property (@(posedge clk) disable iff (rst)
		desig_alarm && !op_repeat && !op_search |=> desig_alarm)
		else $error("alarm dropped without operator");
	chk_settle_wait: assert property (@(posedge clk) disable iff (rst)
		$rose(state == rtas_pkg::ST_SETTLE) |-> !data_read_enable [*8])
		else $error("data read too early after lock");
	cov_lock: cover property (@(posedge clk) disable iff (rst)
		state == rtas_pkg::ST_DESIG ##1 state == rtas_pkg::ST_SETTLE);
	cov_timeout: cover property (@(posedge clk) disable iff (rst)
		$rose(desig_alarm));
	cov_search: cover property (@(posedge clk) disable iff (rst)
		$rose(search_flag));
	cov_realign: cover property (@(posedge clk) disable iff (rst)
		state == rtas_pkg::ST_DATA ##1 state == rtas_pkg::ST_ATTITUDE);
endmodule
`default_nettype wire

// >>> verif/rtas_radar_model.sv
`timescale 1ns/1ps
`default_nettype none
module rtas_radar_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic powered,
	input wire logic lock_ok,
	input wire logic signed [15:0] err_start,
	input wire logic zero_req,
	input wire logic coverage_cmd,
	input wire logic rate_strobe,
	input wire logic signed [15:0] rate_cmd,
	input wire logic track_enable,
	output logic auto_mode_pin,
	output logic zeroing_pin,
	output logic data_good_pin,
	output logic [1:0] coverage_region,
	output logic signed [15:0] point_err_cdeg
);
	int zero_cnt;
	int lock_cnt;
	// ****************************************
	// radar discretes and antenna servo
	// ****************************************
	// control switch is taken as handed over while powered
	assign auto_mode_pin = powered;
	// servo error shrinks only on a rate command and reloads on a zero request, so it is stable between
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			zero_cnt <= 0;
			lock_cnt <= 0;
			zeroing_pin <= 1'b0;
			data_good_pin <= 1'b0;
			coverage_region <= 2'h2;
			point_err_cdeg <= 16'sh0000;
		end else begin
			zero_cnt <= zero_req ? 5 : (zero_cnt > 0 ? zero_cnt - 1 : 0);
			zeroing_pin <= zero_req || zero_cnt > 1;
			if (coverage_cmd)
				coverage_region <= 2'h1;
			if (zero_req)
				point_err_cdeg <= err_start;
			else if (rate_strobe)
				point_err_cdeg <= point_err_cdeg - rate_cmd;
			// lock only once range loops have acquired, i.e. lock_ok
			lock_cnt <= (track_enable && lock_ok) ? 3 : 0;
			data_good_pin <= lock_cnt == 3;
		end
	end
endmodule
`default_nettype wire

// >>> verif/rtas_seq_bench.sv
`timescale 1ns/1ps
`default_nettype none
module rtas_seq_bench;
	localparam int RC = 4;
	localparam int DC = 64;
	localparam int SC = 16;
	localparam int LC = 8;
	logic clk = 0, rst = 1, start = 0, manual_select = 0, attitude_done = 0;
	logic op_repeat = 0, op_search = 0, powered = 0, lock_ok = 0;
	logic [15:0] range_nm = 16'h0000, off_z_cdeg = 16'h0000;
	logic signed [15:0] err_start = 16'sh0000;
	logic los_compute, attitude_req, auto_mode_pin, zeroing_pin;
	logic data_good_pin, zero_req, coverage_cmd, rate_strobe, track_enable;
	logic range_alarm, desig_alarm, manual_flag, search_flag;
	logic data_read_enable;
	logic [1:0] coverage_region;
	logic signed [15:0] point_err_cdeg, rate_cmd;
	logic [3:0] state_code;
	int num_errors = 0, check_count = 0, seed, last_rate = -1, cyc = 0, n;
	int last_los = -1;
	rtas_seq #(.LOS_CYC(LC), .RATE_CYC(RC), .DESIG_CYC(DC), .SETTLE_CYC(SC))
		u_rtas_seq (.clk, .rst, .start, .manual_select, .range_nm,
		.los_compute, .attitude_done, .attitude_req, .auto_mode_pin,
		.zeroing_pin, .data_good_pin, .zero_req, .coverage_region,
		.coverage_cmd, .point_err_cdeg, .off_z_cdeg, .rate_cmd, .rate_strobe,
		.track_enable, .op_repeat, .op_search, .range_alarm, .desig_alarm,
		.manual_flag, .search_flag, .data_read_enable, .state_code);
	rtas_radar_model u_rtas_radar_model (.clk, .rst, .powered, .lock_ok,
		.err_start, .zero_req, .coverage_cmd, .rate_strobe, .rate_cmd,
		.track_enable, .auto_mode_pin, .zeroing_pin, .data_good_pin,
		.coverage_region, .point_err_cdeg);
	// ****************************************
	// clock, compare and wait helpers
	// ****************************************
	always #25 clk = ~clk;
	task automatic check(input logic [15:0] seen, input logic [15:0] exp,
		input string msg);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask
	task summarize;
		$display("checks %0d, errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// bounded wait; a miss shows as a failed state compare
	task automatic wait_state(input int code);
		int i;
		for (i = 0; i < 300 && state_code !== 4'(code); i++)
			@(negedge clk);
		check({12'h000, state_code}, 16'(code), "state");
		if (i == 300)
			summarize();
	endtask
	task automatic go(input logic [15:0] r);
		range_nm = r;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		wait_state(1);
		check(los_compute, 1'b1, "los at start");
	endtask
	task automatic pulse_reset;
		rst = 1'b1;
		@(negedge clk);
		rst = 1'b0;
		check({state_code, track_enable, desig_alarm}, 16'h0000, "reset");
	endtask
	// alignment held off to show the sequence waits for it
	task automatic reach(input int last);
		int path[$];
		path = '{3, 4, 5, 6, 7, 8};
		wait_state(2);
		check(attitude_req, 1'b1, "align request");
		repeat (3) @(negedge clk);
		check({12'h000, state_code}, 16'h0002, "align wait");
		attitude_done = 1'b1;
		foreach (path[i])
			if (path[i] <= last)
				wait_state(path[i]);
		attitude_done = 1'b0;
	endtask
	// ****************************************
	// per-cycle reference model of the port rules
	// ****************************************
	always @(negedge clk) begin
		cyc++;
		if (state_code !== 4'h8)
			last_rate = -1;
		else if (rate_strobe === 1'b1) begin
			if (last_rate >= 0)
				check(16'(cyc - last_rate), 16'(RC), "rate period");
			check(rate_cmd, point_err_cdeg >>> 2, "rate value");
			last_rate = cyc;
		end
		// line of sight refresh runs on its own period in designate
		if (state_code !== 4'h8)
			last_los = -1;
		else if (los_compute === 1'b1) begin
			if (last_los >= 0)
				check(16'(cyc - last_los), 16'(LC), "los period");
			last_los = cyc;
		end
		if (state_code === 4'h8)
			check(coverage_region, 2'h1, "region");
		if (state_code === 4'h8 && track_enable === 1'b1)
			check(point_err_cdeg <= 50 && point_err_cdeg >= -50,
				1'b1, "track early");
		if (state_code === 4'h7)
			check(track_enable, 1'b0, "track in cover");
		if (state_code === 4'h6)
			check(zeroing_pin, 1'b0, "zeroing");
		check(data_read_enable, state_code === 4'hC, "read");
	end
	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		seed = 6748;
		// loaded on the zero request that follows reset release
		err_start = 16'(200 + {$random(seed)} % 800);
		repeat (5) @(negedge clk);
		rst = 1'b0;
		powered = 1'b1;
		repeat (30) @(negedge clk);
		go(16'h0191);
		wait_state(9);
		op_search = 1'b1;
		repeat (3) @(negedge clk);
		op_search = 1'b0;
		check({range_alarm, state_code}, 16'h0019, "range alarm");
		op_repeat = 1'b1;
		@(negedge clk);
		op_repeat = 1'b0;
		wait_state(0);
		check(range_alarm, 1'b0, "alarm clear");
		$display("test range alarm done");
		go(16'h0190);
		reach(8);
		for (n = 0; n < 200 && state_code === 4'h8; n++)
			@(negedge clk);
		check(16'(n), 16'(DC), "timeout");
		check({desig_alarm, state_code}, 16'h0019, "desig alarm");
		op_search = 1'b1;
		@(negedge clk);
		op_search = 1'b0;
		wait_state(10);
		check(search_flag, 1'b1, "search flag");
		pulse_reset();
		$display("test designate timeout done");
		manual_select = 1'b1;
		go(16'h0010);
		reach(5);
		manual_select = 1'b0;
		repeat (4) @(negedge clk);
		check({manual_flag, state_code}, 16'h0015, "manual");
		pulse_reset();
		$display("test manual mode done");
		lock_ok = 1'b1;
		// negative error exercises the magnitude test of the track gate
		err_start = 16'(-(200 + {$random(seed)} % 800));
		go(16'h0190);
		reach(8);
		wait_state(11);
		for (n = 0; n < 100 && state_code === 4'hB; n++)
			@(negedge clk);
		check(16'(n), 16'(SC), "settle");
		wait_state(12);
		off_z_cdeg = 16'({$random(seed)} % 3000);
		repeat (3) @(negedge clk);
		check({12'h000, state_code}, 16'h000C, "data hold");
		off_z_cdeg = 16'h0BB9;
		wait_state(2);
		check(attitude_req, 1'b1, "realign request");
		$display("test lock and data done");
		summarize();
	end
endmodule
`default_nettype wire
